// File: shared/bw_reg_pkg.sv
// Constants, types and helpers of the memory bandwidth regulator.
// Assumes a single 200 MHz clock and an AXI4-Lite register port.
package bw_reg_pkg;
  // Timing: accounting tick is 1/8 us, the unit of the window setting
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_NS       = 125;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [7:0] OFS_FEATURE = 8'h00;
  localparam logic [7:0] OFS_CTRL    = 8'h04;
  localparam logic [7:0] OFS_SEL     = 8'h08;
  localparam logic [7:0] OFS_MIN     = 8'h0C;
  localparam logic [7:0] OFS_MAX     = 8'h10;
  localparam logic [7:0] OFS_WINDOW  = 8'h14;
  localparam logic [7:0] OFS_PROP    = 8'h18;
  localparam logic [7:0] OFS_PRIO    = 8'h1C;
  localparam logic [7:0] OFS_USAGE   = 8'h20;

  // Field positions
  localparam int HARD_CAP_POS   = 31;
  localparam int PROP_EN_POS    = 31;
  localparam int INT_PRIO_LSB   = 0;
  localparam int DS_PRIO_LSB    = 8;
  localparam int FEAT_PROP_POS  = 0;
  localparam int FEAT_INT_POS   = 1;
  localparam int FEAT_DS_POS    = 2;
  localparam int FEAT_NPART_LSB = 8;

  // Reset values and credit ceiling
  localparam logic [15:0] MIN_RESET    = 16'h0000;
  localparam logic [15:0] MAX_RESET    = 16'hFFFF;
  localparam logic [15:0] WIN_RESET    = 16'h0050;
  localparam logic [15:0] STRIDE_RESET = 16'h0000;
  localparam logic [19:0] CREDIT_INIT  = 20'h80000;
  localparam logic [19:0] CREDIT_MAX   = 20'hFFFFF;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ACCT_FIXED, ACCT_MOVING, ACCT_DECAY} acct_mode_t;
  // Encoding order is the service order, highest value served first
  typedef enum logic [1:0] {PREF_NONE, PREF_LOW, PREF_MED, PREF_HIGH} pref_t;

  function automatic logic [31:0] sat_add(input logic [31:0] a, input logic [31:0] b);
    logic [32:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[32] ? 32'hFFFFFFFF : s[31:0];
  endfunction : sat_add

  function automatic logic [31:0] sat_sub(input logic [31:0] a, input logic [31:0] b);
    return (b > a) ? 32'h00000000 : a - b;
  endfunction : sat_sub

  // Fraction of the bandwidth that fits in a given number of ticks
  function automatic logic [31:0] frac_bytes(input logic [15:0] frac, input logic [15:0] ticks,
                                             input logic [15:0] per_tick);
    logic [47:0] p;
    p = {32'h0, frac} * {16'h0, ticks} * {32'h0, per_tick};
    return p[47:16];
  endfunction : frac_bytes
endpackage : bw_reg_pkg

// File: tb/ds_channel_model.sv
// Far-side model: downstream channel that answers requests in order.
// Same clock as the regulator; slow adds stalls and gaps between answers.
`timescale 1ns/1ps
`default_nettype none
module ds_channel_model (
  // Clock, reset and pace
  input  wire logic        clk, rstn, slow,
  // Request side
  input  wire logic        ds_valid,
  output logic             ds_ready,
  input  wire logic [31:0] ds_addr,
  input  wire logic [3:0]  ds_prio,
  // Response side
  input  wire logic        rsp_ready,
  output logic             rsp_valid,
  output logic      [3:0]  rsp_prio,
  output logic      [31:0] rsp_data
);
  logic [35:0] q[$];
  logic [1:0]  t;
  initial {rsp_valid, rsp_prio, rsp_data, t} = '0;
  assign ds_ready = !slow || t[0];
  always @(posedge clk) begin
    t <= t + 2'h1;
    if (!rstn) begin
      t <= 2'h0;
      rsp_valid <= 1'b0;
      q.delete();
    end else begin
      // Answer priority differs from the request so a copy would show
      if (ds_valid && ds_ready)
        q.push_back({~ds_prio, ds_addr});
      // Released data flips so a stale word never looks fresh
      if (rsp_valid && rsp_ready) begin
        rsp_valid <= 1'b0;
        rsp_data  <= ~rsp_data;
        void'(q.pop_front());
      end else if (!rsp_valid && q.size() > 0 && (!slow || t == 2'h0)) begin
        rsp_valid <= 1'b1;
        {rsp_prio, rsp_data} <= q[0];
      end
    end
  end
endmodule : ds_channel_model
`default_nettype wire

// File: tb/mem_bw_regulator_properties.sv
// Checker of grant, downstream hold, response and read-answer relations.
// Bound into the regulator; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module mem_bw_checker #(parameter int NREQ = 4) (
  // Clock, reset and read handshake
  input wire logic            REF_CLK, RESETN, ARVALID, ARREADY, RVALID,
  // Request path
  input wire logic [NREQ-1:0] REQ_VALID, REQ_READY,
  input wire logic            DS_VALID, DS_READY,
  input wire logic [31:0]     DS_ADDR,
  input wire logic [3:0]      DS_PRIO,
  // Response path
  input wire logic            RSP_IN_VALID, RSP_IN_READY, RSP_OUT_VALID,
  input wire logic [3:0]      RSP_IN_PRIO, RSP_OUT_PRIO,
  input wire logic [31:0]     RSP_IN_DATA, RSP_OUT_DATA
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  grant_onehot_a: assert property ($onehot0(REQ_READY)) else $error("two grants");
  grant_valid_a: assert property ((REQ_READY & ~REQ_VALID) == '0) else $error("idle grant");
  grant_issue_a: assert property (|REQ_READY |=> DS_VALID) else $error("grant lost");
  ds_hold_a: assert property (DS_VALID && !DS_READY |=> DS_VALID && $stable(DS_ADDR) && $stable(DS_PRIO))
    else $error("stalled request changed");
  // A grant while stalled would overwrite the waiting request
  ds_block_a: assert property (DS_VALID && !DS_READY |-> REQ_READY == '0) else $error("grant in stall");
  rsp_prio_a: assert property (RSP_IN_VALID && RSP_IN_READY |=> RSP_OUT_PRIO == $past(RSP_IN_PRIO))
    else $error("response priority changed");
  rsp_data_a: assert property (RSP_IN_VALID && RSP_IN_READY |=> RSP_OUT_VALID && RSP_OUT_DATA == $past(RSP_IN_DATA))
    else $error("response data changed");
  read_answer_a: assert property (ARVALID && ARREADY |=> RVALID) else $error("no read answer");
endmodule : mem_bw_checker
bind mem_bw_regulator mem_bw_checker #(.NREQ(NREQ)) u_checker (.*);
`default_nettype wire

// File: tb/test_mem_bw_regulator.sv
// Bench of the regulator: register port, requests and responses.
// Default build of four partitions and requesters; far side is modelled.
`timescale 1ns/1ps
`default_nettype none
module test_mem_bw_regulator import bw_reg_pkg::*; ;
  logic         REF_CLK, RESETN, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY;
  logic         RVALID, RREADY, DS_VALID, DS_READY, RSP_IN_VALID, RSP_IN_READY, RSP_OUT_VALID, RSP_OUT_READY;
  logic         slow, g;
  logic [1:0]   BRESP, RRESP, DS_PARTITION_ID;
  logic [3:0]   WSTRB, REQ_VALID, REQ_READY, DS_PRIO, RSP_IN_PRIO, RSP_OUT_PRIO;
  logic [7:0]   AWADDR, ARADDR, DS_BYTES, REQ_PARTITION_ID;
  logic [15:0]  REQ_PRIO;
  logic [31:0]  WDATA, RDATA, DS_ADDR, RSP_IN_DATA, RSP_OUT_DATA, REQ_BYTES;
  logic [127:0] REQ_ADDR;
  int           n_errors, check_count;

  mem_bw_regulator u_dut (.*);
  ds_channel_model u_far (.clk(REF_CLK), .rstn(RESETN), .slow(slow), .ds_valid(DS_VALID), .ds_ready(DS_READY),
    .ds_addr(DS_ADDR), .ds_prio(DS_PRIO), .rsp_ready(RSP_IN_READY), .rsp_valid(RSP_IN_VALID),
    .rsp_prio(RSP_IN_PRIO), .rsp_data(RSP_IN_DATA));

  initial begin
    REF_CLK = 1'b0;
    forever #2.5 REF_CLK = ~REF_CLK;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    logic       aw, w, b;
    logic [1:0] r;
    int         k = 0;
    {AWADDR, WDATA, AWVALID, WVALID} <= {a, d, 2'h3};
    do begin
      @(negedge REF_CLK);
      {aw, w, b, r} = {AWVALID && AWREADY, WVALID && WREADY, BVALID, BRESP};
      @(posedge REF_CLK);
      if (aw) AWVALID <= 1'b0;
      if (w) WVALID <= 1'b0;
    end while (!b && ++k < 99);
    chk({b, r}, {1'b1, er});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
    logic        ar, v;
    logic [31:0] d;
    logic [1:0]  r;
    int          k = 0;
    {ARADDR, ARVALID} <= {a, 1'b1};
    do begin
      @(negedge REF_CLK);
      {ar, v, d, r} = {ARVALID && ARREADY, RVALID, RDATA, RRESP};
      @(posedge REF_CLK);
      if (ar) ARVALID <= 1'b0;
    end while (!v && ++k < 99);
    chk({v, r}, {1'b1, er});
    if (er == RESP_OKAY) chk(d, e);
  endtask : rd

  // Request from requester i; gives up after lim cycles without a grant
  task automatic req(input int i, input logic [1:0] p, input logic [7:0] by, input logic [31:0] ad, input int lim);
    int k = 0;
    REQ_PARTITION_ID[i*2+:2] <= p;
    REQ_PRIO[i*4+:4]         <= 4'h3;
    REQ_BYTES[i*8+:8]        <= by;
    REQ_ADDR[i*32+:32]       <= ad;
    REQ_VALID[i]             <= 1'b1;
    do begin
      @(negedge REF_CLK);
      g = REQ_READY[i];
      @(posedge REF_CLK);
    end while (!g && ++k < lim);
    REQ_VALID[i] <= 1'b0;
  endtask : req

  task automatic rsp(input logic [3:0] ep, input logic [31:0] ed);
    int k = 0;
    do @(negedge REF_CLK); while (!RSP_OUT_VALID && ++k < 99);
    chk({RSP_OUT_VALID, RSP_OUT_PRIO}, {1'b1, ep});
    chk(RSP_OUT_DATA, ed);
    @(posedge REF_CLK);
  endtask : rsp

  task automatic end_of_test();
    $display("checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  // Whole run is a few thousand cycles; this is far beyond it
  initial begin
    #200000;
    n_errors++;
    end_of_test();
  end

  initial begin
    {RESETN, AWVALID, WVALID, ARVALID, REQ_VALID, slow, n_errors, check_count} = '0;
    {AWADDR, ARADDR, WDATA, REQ_PARTITION_ID, REQ_PRIO, REQ_BYTES, REQ_ADDR} = '0;
    {WSTRB, BREADY, RREADY, RSP_OUT_READY} = 7'h7F;
    repeat (6) @(posedge REF_CLK);
    RESETN <= 1'b1;
    @(posedge REF_CLK);
    rd(OFS_FEATURE, 32'h00000407);
    rd(OFS_MAX, {16'h0, MAX_RESET});
    rd(OFS_WINDOW, {16'h0, WIN_RESET});
    wr(8'h40, 32'h1, RESP_SLVERR);
    rd(8'h40, 32'h0, RESP_SLVERR);
    wr(OFS_SEL, 32'h1);
    wr(OFS_WINDOW, 32'h10);
    rd(OFS_WINDOW, 32'h10);
    wr(OFS_SEL, 32'h0);
    rd(OFS_WINDOW, {16'h0, WIN_RESET});
    wr(OFS_SEL, 32'h1);
    wr(OFS_MIN, 32'h4000);
    wr(OFS_PRIO, 32'hA00);
    req(0, 2'h1, 8'h40, 32'h12345670, 99);
    chk(g, 1'b1);
    rsp(4'h5, 32'h12345670);
    rd(OFS_USAGE, 32'h40);
    repeat (20 * TICK_CYCLES) @(posedge REF_CLK);
    rd(OFS_USAGE, 32'h0);
    slow <= 1'b1;
    wr(OFS_SEL, 32'h2);
    wr(OFS_MAX, 32'h80000000);
    req(1, 2'h2, 8'h20, 32'hA5A50000, 40);
    chk(g, 1'b0);
    wr(OFS_MAX, 32'h0);
    req(1, 2'h2, 8'h20, 32'hA5A50000, 99);
    chk(g, 1'b1);
    @(negedge REF_CLK);
    chk({DS_VALID, DS_PARTITION_ID, DS_BYTES}, {1'b1, 2'h2, 8'h20});
    rsp(4'hF, 32'hA5A50000);
    // Class beats index: requester 1 on partition 1 is high, requester 0 on partition 2 low
    REQ_PARTITION_ID <= 8'h06;
    REQ_VALID        <= 4'h3;
    @(negedge REF_CLK);
    chk(REQ_READY, 4'h2);
    @(posedge REF_CLK);
    REQ_VALID <= 4'h0;
    wr(OFS_CTRL, 32'h1);
    wr(OFS_SEL, 32'h3);
    req(2, 2'h3, 8'h40, 32'h0BAD0000, 99);
    repeat (8 * TICK_CYCLES) @(posedge REF_CLK);
    // Moving window: the charge stays at least three slots, then ages out
    rd(OFS_USAGE, 32'h40);
    repeat (90 * TICK_CYCLES) @(posedge REF_CLK);
    rd(OFS_USAGE, 32'h0);
    wr(OFS_CTRL, 32'h2);
    req(2, 2'h3, 8'h40, 32'h0BAD0000, 99);
    repeat (2 * TICK_CYCLES) @(posedge REF_CLK);
    rd(OFS_USAGE, 32'h0);
    end_of_test();
  end
endmodule : test_mem_bw_regulator
`default_nettype wire

// File: verilog/bw_usage_tracker.sv
// Per-partition usage counter: fixed, moving or decaying window.
// Assumes tick is a one-cycle pulse every 1/8 us on the same clock.
`timescale 1ns/1ps
`default_nettype none
module bw_usage_tracker import bw_reg_pkg::*; #(
  parameter int HIST = 4
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        tick,
  input  wire acct_mode_t  mode,
  input  wire logic [15:0] window_ticks,
  input  wire logic        charge,
  input  wire logic [7:0]  charge_bytes,
  input  wire logic [31:0] decay_step,
  output logic      [31:0] usage
);
  localparam int IW = $clog2(HIST);
  logic [15:0] win_cnt;
  logic [15:0] slot_cnt;
  logic [IW-1:0] slot_idx;
  logic [IW-1:0] next_idx;
  logic [31:0] slots [HIST];
  logic [15:0] win_len;
  logic [15:0] slot_len;
  logic window_end;
  logic slot_end;
  logic [31:0] next_usage;

  assign win_len    = (window_ticks == 16'h0000) ? 16'h0001 : window_ticks;
  assign slot_len   = (win_len < 16'(HIST)) ? 16'h0001 : 16'(win_len / 16'(HIST));
  assign window_end = tick && (win_cnt >= win_len - 16'h0001);
  assign slot_end   = tick && (slot_cnt >= slot_len - 16'h0001);
  assign next_idx   = (slot_idx == IW'(HIST - 1)) ? '0 : slot_idx + IW'(1);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      win_cnt  <= 16'h0000;
      slot_cnt <= 16'h0000;
      slot_idx <= '0;
    end else if (tick) begin
      win_cnt  <= window_end ? 16'h0000 : win_cnt + 16'h0001;
      slot_cnt <= slot_end ? 16'h0000 : slot_cnt + 16'h0001;
      if (slot_end) begin
        slot_idx <= next_idx;
      end
    end
  end

  always_comb begin
    next_usage = usage;
    case (mode)
      ACCT_FIXED: if (window_end) next_usage = 32'h00000000;
      ACCT_MOVING: if (slot_end) next_usage = sat_sub(usage, slots[next_idx]);
      ACCT_DECAY: if (tick) next_usage = sat_sub(usage, decay_step);
      default: next_usage = usage;
    endcase
    if (charge) next_usage = sat_add(next_usage, {24'h0, charge_bytes});
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      usage <= 32'h00000000;
    end else begin
      usage <= next_usage;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < HIST; i++) slots[i] <= 32'h00000000;
    end else if (slot_end) begin
      slots[next_idx] <= charge ? {24'h0, charge_bytes} : 32'h00000000;
    end else if (charge) begin
      slots[slot_idx] <= sat_add(slots[slot_idx], {24'h0, charge_bytes});
    end
  end
endmodule : bw_usage_tracker
`default_nettype wire

// File: verilog/mem_bw_regulator.sv
// Memory bandwidth regulator: arbitrates upstream requests onto one
// downstream port by preference class, priority and stride credit.
// Assumes requesters and downstream share REF_CLK; AXI4-Lite registers.
// Functional notes
// - Min and max limits are 16-bit fractions of available downstream bandwidth.
// - Hard cap bit stops a partition exceeding its maximum fraction.
// - Usage is tracked per partition over a fixed or moving window.
// - Window width reads back for the partition chosen by the selector.
// - Window width writes are fixed-point, in microseconds (eighths).
// - In fixed windows, priorities break ties within a preference class.
// - Window expiry zeroes usage; only unserviced requests carry over.
// - Moving window adds on issue and subtracts as commands age out.
// - Moving window keeps command history besides the per-partition counter.
// - Decay mode lowers usage proportional to allocation, never below zero.
// - Stride is unsigned; share follows stride against other contenders.
// - Feature register reports whether stride control exists.
// - Stride regulation applies only when the partition enable bit is 1.
// - Maximum limiting and stride regulation act together when both enabled.
// - Internal priority orders waiting requests of equal preference.
// - Internal and downstream priority options are independent.
// - Downstream priority option tags requests with the partition priority.
// - Without it, downstream requests carry the incoming priority.
// - Response priority passes upstream unchanged.
// - Without internal priority, incoming priority orders requests.
// - Classes: below min high, below max medium, over max low or held.
// - Unused bandwidth never carries over as credit.
`timescale 1ns/1ps
`default_nettype none
module mem_bw_regulator import bw_reg_pkg::*; #(
  parameter int          NPART          = 4,
  parameter int          NREQ           = 4,
  parameter int          HIST           = 4,
  parameter logic [15:0] BYTES_PER_TICK = 16'h0320,
  parameter bit          PROP_STRIDE_PRESENT = 1'b1,
  parameter bit          HAS_INT_PRIO   = 1'b1,
  parameter bit          HAS_DS_PRIO    = 1'b1,
  localparam int         PW             = $clog2(NPART)
) (
  // Clock and reset
  input  wire logic              REF_CLK,
  input  wire logic              RESETN,
  // AXI4-Lite register port
  input  wire logic              AWVALID,
  output logic                   AWREADY,
  input  wire logic [7:0]        AWADDR,
  input  wire logic              WVALID,
  output logic                   WREADY,
  input  wire logic [31:0]       WDATA,
  input  wire logic [3:0]        WSTRB,
  output logic                   BVALID,
  input  wire logic              BREADY,
  output logic      [1:0]        BRESP,
  input  wire logic              ARVALID,
  output logic                   ARREADY,
  input  wire logic [7:0]        ARADDR,
  output logic                   RVALID,
  input  wire logic              RREADY,
  output logic      [31:0]       RDATA,
  output logic      [1:0]        RRESP,
  // Upstream requests
  input  wire logic [NREQ-1:0]   REQ_VALID,
  output logic      [NREQ-1:0]   REQ_READY,
  input  wire logic [NREQ*PW-1:0] REQ_PARTITION_ID,
  input  wire logic [NREQ*4-1:0] REQ_PRIO,
  input  wire logic [NREQ*8-1:0] REQ_BYTES,
  input  wire logic [NREQ*32-1:0] REQ_ADDR,
  // Downstream requests
  output logic                   DS_VALID,
  input  wire logic              DS_READY,
  output logic      [31:0]       DS_ADDR,
  output logic      [PW-1:0]     DS_PARTITION_ID,
  output logic      [3:0]        DS_PRIO,
  output logic      [7:0]        DS_BYTES,
  // Responses, downstream to upstream
  input  wire logic              RSP_IN_VALID,
  output logic                   RSP_IN_READY,
  input  wire logic [3:0]        RSP_IN_PRIO,
  input  wire logic [31:0]       RSP_IN_DATA,
  output logic                   RSP_OUT_VALID,
  input  wire logic              RSP_OUT_READY,
  output logic      [3:0]        RSP_OUT_PRIO,
  output logic      [31:0]       RSP_OUT_DATA
);
  // Configuration state
  acct_mode_t  mode;
  logic [PW-1:0] partition_selector;
  logic [15:0] min_frac  [NPART];
  logic [15:0] max_frac  [NPART];
  logic        hard_cap_bit [NPART];
  logic [15:0] win_width [NPART];
  logic [15:0] stride_minus_one [NPART];
  logic        prop_en   [NPART];
  logic [3:0]  int_prio  [NPART];
  logic [3:0]  ds_prio   [NPART];
  logic [19:0] credit    [NPART];
  logic [31:0] usage     [NPART];
  pref_t       pref      [NPART];

  // Bus state
  logic        aw_held;
  logic [7:0]  aw_addr;
  logic        w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;

  // Tick divider
  logic [7:0]  tick_cnt;
  logic        tick;

  // Arbitration
  logic [NREQ-1:0] req_ok;
  logic        found;
  logic [$clog2(NREQ+1)-1:0] best;
  logic [25:0] best_key;
  logic [PW-1:0] win_pid;
  logic        fire;
  logic [NPART-1:0] contend;
  logic [19:0] stride_sum;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[b*8 +: 8] = d[b*8 +: 8];
    end
    return r;
  endfunction : merge

  function automatic logic [15:0] stride(input logic [15:0] m1);
    return (m1 == 16'hFFFF) ? m1 : m1 + 16'h0001;
  endfunction : stride

  // Register image of the selected partition, shared by read and write
  function automatic logic [31:0] reg_image(input logic [7:0] a, input logic [PW-1:0] p);
    logic [31:0] r;
    r = 32'h00000000;
    if (a == OFS_FEATURE) begin
      r[FEAT_PROP_POS] = PROP_STRIDE_PRESENT;
      r[FEAT_INT_POS]  = HAS_INT_PRIO;
      r[FEAT_DS_POS]   = HAS_DS_PRIO;
      r[FEAT_NPART_LSB +: 8] = 8'(NPART);
    end else if (a == OFS_CTRL) begin
      r[1:0] = mode;
    end else if (a == OFS_SEL) begin
      r[PW-1:0] = partition_selector;
    end else if (a == OFS_MIN) begin
      r[15:0] = min_frac[p];
    end else if (a == OFS_MAX) begin
      r[15:0] = max_frac[p];
      r[HARD_CAP_POS] = hard_cap_bit[p];
    end else if (a == OFS_WINDOW) begin
      r[15:0] = win_width[p];
    end else if (a == OFS_PROP) begin
      r[15:0] = stride_minus_one[p];
      r[PROP_EN_POS] = prop_en[p];
    end else if (a == OFS_PRIO) begin
      r[INT_PRIO_LSB +: 4] = int_prio[p];
      r[DS_PRIO_LSB +: 4]  = ds_prio[p];
    end else if (a == OFS_USAGE) begin
      r = usage[p];
    end
    return r;
  endfunction : reg_image

  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= OFS_USAGE);
  endfunction : mapped

  assign tick = (tick_cnt == 8'(TICK_CYCLES - 1));

  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      tick_cnt <= 8'h00;
    end else begin
      tick_cnt <= tick ? 8'h00 : tick_cnt + 8'h01;
    end
  end

  // Write channel: address and data may arrive in either order
  assign AWREADY  = !aw_held && !BVALID;
  assign WREADY   = !w_held && !BVALID;
  assign do_write = aw_held && w_held;

  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held  <= 1'b0;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
      BVALID  <= 1'b0;
      BRESP   <= RESP_OKAY;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_held <= 1'b1;
        w_data <= WDATA;
        w_strb <= WSTRB;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        BVALID  <= 1'b1;
        BRESP   <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  // Read channel: one outstanding read, answer one cycle after acceptance
  assign ARREADY = !RVALID;

  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      RVALID <= 1'b0;
      RDATA  <= 32'h00000000;
      RRESP  <= RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      RVALID <= 1'b1;
      RDATA  <= reg_image(ARADDR, partition_selector);
      RRESP  <= mapped(ARADDR) ? RESP_OKAY : RESP_SLVERR;
    end else if (RREADY) begin
      RVALID <= 1'b0;
    end
  end

  // Global control; an undefined mode code is ignored
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      mode               <= ACCT_FIXED;
      partition_selector <= '0;
    end else if (do_write) begin
      if (aw_addr == OFS_CTRL && w_strb[0] && w_data[1:0] != 2'b11) begin
        mode <= acct_mode_t'(w_data[1:0]);
      end else if (aw_addr == OFS_SEL) begin
        partition_selector <= PW'(merge(reg_image(OFS_SEL, partition_selector), w_data, w_strb));
      end
    end
  end

  // Per-partition settings, written through the selector
  always_ff @(posedge REF_CLK) begin
    logic [31:0] v;
    v = merge(reg_image(aw_addr, partition_selector), w_data, w_strb);
    if (!RESETN) begin
      for (int p = 0; p < NPART; p++) begin
        min_frac[p]         <= MIN_RESET;
        max_frac[p]         <= MAX_RESET;
        hard_cap_bit[p]     <= 1'b0;
        win_width[p]        <= WIN_RESET;
        stride_minus_one[p] <= STRIDE_RESET;
        prop_en[p]          <= 1'b0;
        int_prio[p]         <= 4'h0;
        ds_prio[p]          <= 4'h0;
      end
    end else if (do_write) begin
      if (aw_addr == OFS_MIN) begin
        min_frac[partition_selector] <= v[15:0];
      end else if (aw_addr == OFS_MAX) begin
        max_frac[partition_selector]     <= v[15:0];
        hard_cap_bit[partition_selector] <= v[HARD_CAP_POS];
      end else if (aw_addr == OFS_WINDOW) begin
        win_width[partition_selector] <= v[15:0];
      end else if (aw_addr == OFS_PROP && PROP_STRIDE_PRESENT) begin
        stride_minus_one[partition_selector] <= v[15:0];
        prop_en[partition_selector]          <= v[PROP_EN_POS];
      end else if (aw_addr == OFS_PRIO) begin
        int_prio[partition_selector] <= v[INT_PRIO_LSB +: 4];
        ds_prio[partition_selector]  <= v[DS_PRIO_LSB +: 4];
      end
    end
  end

  // Usage trackers and preference classes
  for (genvar p = 0; p < NPART; p++) begin : g_part
    logic [31:0] min_bytes;
    logic [31:0] max_bytes;
    logic [31:0] decay_raw;
    assign min_bytes = frac_bytes(min_frac[p], win_width[p], BYTES_PER_TICK);
    assign max_bytes = frac_bytes(max_frac[p], win_width[p], BYTES_PER_TICK);
    assign decay_raw = frac_bytes(max_frac[p], 16'h0001, BYTES_PER_TICK);

    bw_usage_tracker #(
      .HIST(HIST)
    ) u_track (
      .clk          (REF_CLK),
      .resetn       (RESETN),
      .tick         (tick),
      .mode         (mode),
      .window_ticks (win_width[p]),
      .charge       (fire && win_pid == PW'(p)),
      .charge_bytes (REQ_BYTES[best*8 +: 8]),
      .decay_step   ((decay_raw == 32'h0) ? 32'h1 : decay_raw),
      .usage        (usage[p])
    );

    always_comb begin
      if (usage[p] < min_bytes) begin
        pref[p] = PREF_HIGH;
      end else if (usage[p] < max_bytes) begin
        pref[p] = PREF_MED;
      end else if (!hard_cap_bit[p]) begin
        pref[p] = PREF_LOW;
      end else begin
        pref[p] = PREF_NONE;
      end
    end
  end

  // Arbitration: class, then priority, then stride credit
  always_comb begin
    logic [PW-1:0] pid;
    logic [3:0]    prio;
    logic [19:0]   cr;
    logic [25:0]   key;
    pid      = '0;
    prio     = 4'h0;
    cr       = CREDIT_INIT;
    key      = '0;
    found    = 1'b0;
    best     = '0;
    best_key = '0;
    contend  = '0;
    req_ok   = '0;
    for (int i = 0; i < NREQ; i++) begin
      pid = REQ_PARTITION_ID[i*PW +: PW];
      prio = HAS_INT_PRIO ? int_prio[pid] : REQ_PRIO[i*4 +: 4];
      cr = (PROP_STRIDE_PRESENT && prop_en[pid]) ? credit[pid] : CREDIT_INIT;
      key = {pref[pid], prio, cr};
      req_ok[i] = REQ_VALID[i] && pref[pid] != PREF_NONE;
      if (req_ok[i] && PROP_STRIDE_PRESENT && prop_en[pid]) contend[pid] = 1'b1;
      if (req_ok[i] && (!found || key > best_key)) begin
        found    = 1'b1;
        best     = ($clog2(NREQ+1))'(i);
        best_key = key;
      end
    end
  end

  assign win_pid   = REQ_PARTITION_ID[best*PW +: PW];
  assign fire      = found && (!DS_VALID || DS_READY);
  assign REQ_READY = fire ? (NREQ'(1) << best) : '0;

  always_comb begin
    stride_sum = 20'h00000;
    for (int p = 0; p < NPART; p++) begin
      if (contend[p]) stride_sum = stride_sum + {4'h0, stride(stride_minus_one[p])};
    end
  end

  // credit moves in proportion to stride
  // applies after the maximum class filter
  always_ff @(posedge REF_CLK) begin
    int c;
    c = 0;
    if (!RESETN) begin
      for (int p = 0; p < NPART; p++) credit[p] <= CREDIT_INIT;
    end else if (fire && contend[win_pid]) begin
      for (int p = 0; p < NPART; p++) begin
        c = int'(credit[p]) + (contend[p] ? int'(stride(stride_minus_one[p])) : 0);
        if (PW'(p) == win_pid) c = c - int'(stride_sum);
        if (c < 0) c = 0;
        if (c > int'(CREDIT_MAX)) c = int'(CREDIT_MAX);
        credit[p] <= 20'(c);
      end
    end
  end

  // Downstream output stage
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      DS_VALID        <= 1'b0;
      DS_ADDR         <= 32'h00000000;
      DS_PARTITION_ID <= '0;
      DS_PRIO         <= 4'h0;
      DS_BYTES        <= 8'h00;
    end else if (fire) begin
      DS_VALID        <= 1'b1;
      DS_ADDR         <= REQ_ADDR[best*32 +: 32];
      DS_PARTITION_ID <= win_pid;
      DS_PRIO  <= HAS_DS_PRIO ? ds_prio[win_pid] : REQ_PRIO[best*4 +: 4];
      DS_BYTES <= REQ_BYTES[best*8 +: 8];
    end else if (DS_READY) begin
      DS_VALID <= 1'b0;
    end
  end

  assign RSP_IN_READY = !RSP_OUT_VALID || RSP_OUT_READY;

  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      RSP_OUT_VALID <= 1'b0;
      RSP_OUT_PRIO  <= 4'h0;
      RSP_OUT_DATA  <= 32'h00000000;
    end else if (RSP_IN_VALID && RSP_IN_READY) begin
      RSP_OUT_VALID <= 1'b1;
      RSP_OUT_PRIO  <= RSP_IN_PRIO;
      RSP_OUT_DATA  <= RSP_IN_DATA;
    end else if (RSP_OUT_READY) begin
      RSP_OUT_VALID <= 1'b0;
    end
  end
endmodule : mem_bw_regulator
`default_nettype wire
